// ===== rtl/ulvs_pkg.sv
// Package with the constants and types of the ULPI transmit and supply-valid block.
//
// Functional notes
// - Mode 11b stops adding SYNC; the stop byte decides the EOP.
// - Raw mode still does NRZI and stuffing.
// - Stuffing is never switched per byte.
// - In raw mode, stop with FEh sends unstuffed EOP.
// - In raw mode, stop with 00h ends without EOP.
// - SOF identifier A5h gives long EOP.
// - One session-valid flag for both roles.
// - Comparator events gated by control registers.
// - Use-external 0 selects internal comparator.
// - External 1, bypass 1, invert 0: pin.
// - Bypass 0, invert 1: active-high fault qualifies.
// - Bypass 0, invert 0: active-low fault qualifies.
// - Mode decodes normal, quiet, unstuffed, raw.
package ulvs_pkg;
  // Register addresses on the register port.
  localparam logic [5:0] ADDR_FUNC = 6'h04;
  localparam logic [5:0] ADDR_INTF = 6'h07;
  localparam logic [5:0] ADDR_OTG = 6'h0A;
  localparam logic [5:0] ADDR_RISE = 6'h0D;
  localparam logic [5:0] ADDR_FALL = 6'h10;
  localparam logic [5:0] ADDR_STAT = 6'h13;
  localparam logic [5:0] ADDR_LATCH = 6'h14;
  // Reset values.
  localparam logic [7:0] RST_FUNC = 8'h41;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQEN = 8'h1F;
  // Field positions.
  localparam int MODE_LSB = 3;
  localparam int INV_BIT = 5;
  localparam int BYP_BIT = 6;
  localparam int USEEXT_BIT = 7;
  localparam int VBUS_BIT = 1;
  localparam int SESS_BIT = 2;
  // Transmit encoding modes.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_QUIET = 2'h1;
  localparam logic [1:0] MODE_NOSTUFF = 2'h2;
  localparam logic [1:0] MODE_RAW = 2'h3;
  // Stream bytes.
  localparam logic [7:0] CMD_NOPID = 8'h40;
  localparam logic [7:0] SYNC_BYTE = 8'h80;
  localparam logic [7:0] EOP_BYTE = 8'hFE;
  localparam logic [7:0] NOEOP_BYTE = 8'h00;
  localparam logic [7:0] SOF_PID = 8'hA5;
  // Bit counts.
  localparam logic [5:0] EOP_SHORT = 6'h08;
  localparam logic [5:0] EOP_LONG = 6'h28;
  localparam logic [2:0] STUFF_RUN = 3'h6;
  // Control fields that steer the block.
  typedef struct packed {
    logic useExt;
    logic bypass;
    logic invert;
    logic [1:0] mode;
  } ulvs_ctl_t;
  // Transmit states.
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_EOP} ulvs_st_t;
endpackage

// ===== rtl/ulvs_top.sv
// ULPI high-speed transmit serializer with supply-valid source selection.
`timescale 1ns/1ps
`default_nettype none
module ulvs_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [7:0] linkData,
  input wire logic linkStp,
  output logic linkNxt,
  output logic lineLevel,
  output logic lineStb,
  output logic lineOe,
  input wire logic externalValidPin,
  input wire logic intSupplyComp,
  input wire logic sessionComp,
  output logic rxcmdStb,
  output logic [7:0] rxcmdData
);
  // Software registers.
  logic [7:0] func_ff;
  logic [7:0] intf_ff;
  logic [7:0] otg_ff;
  logic [7:0] rise_ff;
  logic [7:0] fall_ff;
  logic [7:0] latch_ff;
  logic [7:0] rdData_ff;
  // Live control fields gathered from the registers.
  ulvs_pkg::ulvs_ctl_t ctl;
  assign ctl.useExt = otg_ff[ulvs_pkg::USEEXT_BIT];
  assign ctl.bypass = intf_ff[ulvs_pkg::BYP_BIT];
  assign ctl.invert = intf_ff[ulvs_pkg::INV_BIT];
  assign ctl.mode = func_ff[ulvs_pkg::MODE_LSB+:2];
  // Transmit state.
  ulvs_pkg::ulvs_st_t state_ff;
  ulvs_pkg::ulvs_st_t nxt_state;
  logic [7:0] shift_ff;
  logic [2:0] bitCnt_ff;
  logic [2:0] ones_ff;
  logic loadSlot_ff;
  logic [1:0] byteIdx_ff;
  logic sof_ff;
  logic [1:0] txMode_ff;
  logic stuffOn_ff;
  logic eopLong_ff;
  logic [5:0] eopCnt_ff;
  logic lvl_ff;
  logic stb_ff;
  logic oe_ff;
  // Decode of the transmit stream.
  wire isIdle = state_ff == ulvs_pkg::ST_IDLE;
  wire inData = state_ff == ulvs_pkg::ST_DATA;
  wire inEop = state_ff == ulvs_pkg::ST_EOP;
  wire isRaw = txMode_ff == ulvs_pkg::MODE_RAW;
  // A stuffed zero is due after six ones while stuffing is on.
  wire stuffNow = inData && stuffOn_ff && ones_ff == ulvs_pkg::STUFF_RUN;
  wire takeCmd = isIdle && linkData == ulvs_pkg::CMD_NOPID;
  wire takeByte = inData && loadSlot_ff && !stuffNow;
  wire emitData = inData && (!loadSlot_ff || stuffNow);
  wire bitStb = emitData || inEop;
  wire endPkt = takeByte && linkStp;
  // The closing byte decides how a raw packet ends.
  wire rawNoEop = isRaw && linkData == ulvs_pkg::NOEOP_BYTE;
  wire rawFe = isRaw && linkData == ulvs_pkg::EOP_BYTE;
  // Chirp, resume and quiet packets end with no EOP of the block's own.
  wire needEop = (txMode_ff == ulvs_pkg::MODE_NORMAL) || (isRaw && !rawNoEop);
  // The identifier follows the link's own SYNC byte in raw mode.
  wire [1:0] pidIdx = isRaw ? 2'h1 : 2'h0;
  wire isSofPid = takeByte && !linkStp && byteIdx_ff == pidIdx &&
                  linkData == ulvs_pkg::SOF_PID;
  wire [5:0] eopLen = eopLong_ff ? ulvs_pkg::EOP_LONG : ulvs_pkg::EOP_SHORT;
  wire eopLast = inEop && eopCnt_ff == eopLen - 6'h01;
  // The EOP is one zero then ones, never stuffed.
  wire eopBit = eopCnt_ff != 6'h00;
  wire txBit = inEop ? eopBit : (stuffNow ? 1'b0 : shift_ff[0]);
  // NRZI holds the level for a one and toggles for a zero.
  wire nrziOn = txMode_ff != ulvs_pkg::MODE_NOSTUFF;
  wire nxt_lvl = nrziOn ? (txBit ? lvl_ff : ~lvl_ff) : txBit;
  // Quiet mode consumes bytes but never drives the line.
  wire nxt_oe = !isIdle && txMode_ff != ulvs_pkg::MODE_QUIET;

  // The link sees a byte taken in the cycle that it is offered.
  assign linkNxt = takeCmd || takeByte;
  // Next state of the transmit sequencer.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ulvs_pkg::ST_IDLE: begin
        // A NOPID command opens a packet.
        if (takeCmd) begin
          nxt_state = ulvs_pkg::ST_DATA;
        end
      end
      ulvs_pkg::ST_DATA: begin
        // Stop either closes with an EOP or ends at once.
        if (endPkt) begin
          nxt_state = needEop ? ulvs_pkg::ST_EOP : ulvs_pkg::ST_IDLE;
        end
      end
      ulvs_pkg::ST_EOP: begin
        // Return to idle after the last EOP bit.
        if (eopLast) begin
          nxt_state = ulvs_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ulvs_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= ulvs_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Packet settings are frozen when the command is taken.
  always_ff @(posedge clock) begin
    if (rst) begin
      txMode_ff <= ulvs_pkg::MODE_NORMAL;
      stuffOn_ff <= 1'b0;
    end else if (takeCmd) begin
      txMode_ff <= ctl.mode;
      // Stuffing stays fixed for the whole packet.
      stuffOn_ff <= ctl.mode != ulvs_pkg::MODE_NOSTUFF;
    end
  end

  // Shifter, bit counter and byte slot.
  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      loadSlot_ff <= 1'b0;
    end else if (takeCmd) begin
      // Normal mode starts with its own SYNC; raw waits for the link's.
      shift_ff <= ulvs_pkg::SYNC_BYTE;
      bitCnt_ff <= 3'h0;
      loadSlot_ff <= ctl.mode == ulvs_pkg::MODE_RAW;
    end else if (takeByte) begin
      shift_ff <= linkData;
      bitCnt_ff <= 3'h0;
      loadSlot_ff <= linkStp;
    end else if (emitData && !stuffNow) begin
      shift_ff <= {1'b0, shift_ff[7:1]};
      bitCnt_ff <= bitCnt_ff + 3'h1;
      loadSlot_ff <= bitCnt_ff == 3'h7;
    end
  end

  // Run of ones for the stuffing decision.
  always_ff @(posedge clock) begin
    if (rst || takeCmd) begin
      ones_ff <= 3'h0;
    end else if (emitData) begin
      ones_ff <= (txBit && !stuffNow) ? ones_ff + 3'h1 : 3'h0;
    end
  end

  // Byte index and start-of-frame detection.
  always_ff @(posedge clock) begin
    if (rst || takeCmd) begin
      byteIdx_ff <= 2'h0;
      sof_ff <= 1'b0;
    end else if (takeByte) begin
      byteIdx_ff <= (byteIdx_ff == 2'h3) ? byteIdx_ff : byteIdx_ff + 2'h1;
      sof_ff <= sof_ff || isSofPid;
    end
  end

  // EOP length and bit counter.
  always_ff @(posedge clock) begin
    if (rst) begin
      eopLong_ff <= 1'b0;
      eopCnt_ff <= 6'h00;
    end else if (endPkt) begin
      // A start-of-frame packet ends with the long EOP.
      eopLong_ff <= sof_ff;
      eopCnt_ff <= 6'h00;
    end else if (inEop) begin
      eopCnt_ff <= eopCnt_ff + 6'h01;
    end
  end

  // Line outputs from flip-flops.
  always_ff @(posedge clock) begin
    if (rst) begin
      lvl_ff <= 1'b1;
      stb_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      if (bitStb) begin
        lvl_ff <= nxt_lvl;
      end
      stb_ff <= bitStb && nxt_oe;
      oe_ff <= nxt_oe;
    end
  end
  assign lineLevel = lvl_ff;
  assign lineStb = stb_ff;
  assign lineOe = oe_ff;

  // Supply-valid selection.
  logic [1:0] extS_ff;
  logic [1:0] intS_ff;
  logic [1:0] sesS_ff;
  // Asynchronous comparator and pin levels pass two flip-flops.
  always_ff @(posedge clock) begin
    if (rst) begin
      extS_ff <= 2'h0;
      intS_ff <= 2'h0;
      sesS_ff <= 2'h0;
    end else begin
      extS_ff <= {extS_ff[0], externalValidPin};
      intS_ff <= {intS_ff[0], intSupplyComp};
      sesS_ff <= {sesS_ff[0], sessionComp};
    end
  end
  wire extPin = extS_ff[1];
  wire intValid = intS_ff[1];
  // One session flag serves A and B roles alike.
  wire sessionValidFlag = sesS_ff[1];
  wire passSel = ctl.invert ? ~extPin : extPin;
  // The fault input blocks the internal comparator while active.
  wire faultSel = intValid & (ctl.invert ? ~extPin : extPin);
  wire extSel = ctl.bypass ? passSel : faultSel;
  wire aDeviceSupplyValid = ctl.useExt ? extSel : intValid;
  wire [7:0] statusNow = {5'h00, sessionValidFlag, aDeviceSupplyValid, 1'b0};

  // Event detection against the previous status.
  logic [7:0] statPrev_ff;
  logic rxStb_ff;
  logic [7:0] rxData_ff;
  wire [7:0] riseEv = statusNow & ~statPrev_ff & rise_ff;
  wire [7:0] fallEv = ~statusNow & statPrev_ff & fall_ff;
  wire [7:0] events = riseEv | fallEv;
  wire latchRd = regRd && regAddr == ulvs_pkg::ADDR_LATCH;
  // Status history and receive-command update.
  always_ff @(posedge clock) begin
    if (rst) begin
      statPrev_ff <= 8'h00;
      rxStb_ff <= 1'b0;
      rxData_ff <= 8'h00;
    end else begin
      statPrev_ff <= statusNow;
      rxStb_ff <= events != 8'h00;
      if (events != 8'h00) begin
        rxData_ff <= statusNow;
      end
    end
  end
  assign rxcmdStb = rxStb_ff;
  assign rxcmdData = rxData_ff;

  // Register writes; the latch clears on read and a new event wins.
  wire wrFunc = regWr && regAddr == ulvs_pkg::ADDR_FUNC;
  wire wrIntf = regWr && regAddr == ulvs_pkg::ADDR_INTF;
  wire wrOtg = regWr && regAddr == ulvs_pkg::ADDR_OTG;
  wire wrRise = regWr && regAddr == ulvs_pkg::ADDR_RISE;
  wire wrFall = regWr && regAddr == ulvs_pkg::ADDR_FALL;
  always_ff @(posedge clock) begin
    if (rst) begin
      func_ff <= ulvs_pkg::RST_FUNC;
      intf_ff <= ulvs_pkg::RST_CTRL;
      otg_ff <= ulvs_pkg::RST_CTRL;
      rise_ff <= ulvs_pkg::RST_IRQEN;
      fall_ff <= ulvs_pkg::RST_IRQEN;
      latch_ff <= 8'h00;
    end else begin
      if (wrFunc) begin
        func_ff <= regWrData;
      end
      if (wrIntf) begin
        intf_ff <= regWrData;
      end
      if (wrOtg) begin
        otg_ff <= regWrData;
      end
      if (wrRise) begin
        rise_ff <= regWrData;
      end
      if (wrFall) begin
        fall_ff <= regWrData;
      end
      latch_ff <= (latchRd ? 8'h00 : latch_ff) | events;
    end
  end

  // Read mux; unmapped addresses read zero.
  wire [7:0] rdMux =
    (regAddr == ulvs_pkg::ADDR_FUNC) ? func_ff :
    (regAddr == ulvs_pkg::ADDR_INTF) ? intf_ff :
    (regAddr == ulvs_pkg::ADDR_OTG) ? otg_ff :
    (regAddr == ulvs_pkg::ADDR_RISE) ? rise_ff :
    (regAddr == ulvs_pkg::ADDR_FALL) ? fall_ff :
    (regAddr == ulvs_pkg::ADDR_STAT) ? statusNow :
    (regAddr == ulvs_pkg::ADDR_LATCH) ? latch_ff : 8'h00;
  // Read data stand for the one cycle after the strobe.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= regRd ? rdMux : 8'h00;
    end
  end
  assign regRdData = rdData_ff;

  // Checks on the transmit path.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_raw_no_sync: assert property (
    takeCmd && ctl.mode == ulvs_pkg::MODE_RAW |=> loadSlot_ff && inData)
    else $error("raw packet started with a SYNC of its own");
  chk_stuff_zero: assert property (
    emitData && stuffOn_ff && ones_ff == 3'h6 |-> !txBit ##1 ones_ff == 3'h0)
    else $error("stuffed zero missing after six ones");
  chk_stuff_fixed: assert property (
    !isIdle && !$past(isIdle) |-> $stable(stuffOn_ff))
    else $error("stuffing changed inside a packet");
  chk_fe_eop: assert property (
    endPkt && rawFe && !sof_ff |=> inEop [*8] ##1 isIdle)
    else $error("closing FEh did not give an eight bit EOP");
  chk_zero_noeop: assert property (
    endPkt && rawNoEop |=> isIdle)
    else $error("closing 00h still sent an EOP");
  chk_sof_long: assert property (
    endPkt && isRaw && !rawNoEop && sof_ff |=> eopLong_ff ##39 eopLast)
    else $error("SOF packet lacked the long EOP");
  chk_eop_ones: assert property (
    inEop && eopCnt_ff != 6'h00 |-> txBit)
    else $error("EOP bit after the first was not a one");
  chk_quiet_line: assert property (
    !isIdle && txMode_ff == ulvs_pkg::MODE_QUIET |=> !lineOe)
    else $error("line driven in non-driving mode");
  // Checks on the supply-valid source and on the session status event.
  chk_int_source: assert property (
    !ctl.useExt |-> aDeviceSupplyValid == intValid)
    else $error("internal comparator not selected");
  chk_pass_pin: assert property (
    ctl.useExt && ctl.bypass && !ctl.invert |-> aDeviceSupplyValid == extPin)
    else $error("pass-through pin not reported");
  chk_pass_inv: assert property (
    ctl.useExt && ctl.bypass && ctl.invert |-> aDeviceSupplyValid == !extPin)
    else $error("inverted pin not reported");
  chk_fault_hi: assert property (
    ctl.useExt && !ctl.bypass && ctl.invert |-> aDeviceSupplyValid == (intValid && !extPin))
    else $error("active-high fault not qualified");
  chk_fault_lo: assert property (
    ctl.useExt && !ctl.bypass && !ctl.invert |-> aDeviceSupplyValid == (intValid && extPin))
    else $error("active-low fault not qualified");
  chk_event_rx: assert property (
    $rose(sessionValidFlag) && rise_ff[ulvs_pkg::SESS_BIT] |=> rxcmdStb &&
      rxcmdData[ulvs_pkg::SESS_BIT] && latch_ff[ulvs_pkg::SESS_BIT])
    else $error("rising session event lost");
  // Main scenarios.
  cov_raw_fe: cover property (endPkt && rawFe);
  cov_raw_zero: cover property (endPkt && rawNoEop);
  cov_sof_eop: cover property (eopLast && eopLong_ff);
  cov_fault_sel: cover property (ctl.useExt && !ctl.bypass && $fell(aDeviceSupplyValid));
endmodule
`default_nettype wire

// ===== dv/ulvs_link_model.sv
// Link controller model: drives transmit bytes and records line cells.
`timescale 1ns/1ps
`default_nettype none
module ulvs_link_model (
  input wire logic clock,
  input wire logic linkNxt,
  input wire logic lineLevel,
  input wire logic lineStb,
  input wire logic lineOe,
  output logic [7:0] linkData,
  output logic linkStp
);
  // Raw level and NRZI-decoded bit of every cell seen on the line.
  logic rawQ[$];
  logic decQ[$];
  // Level of the previous cell; a held level decodes as a 1.
  logic prevLv = 1'b1;
  // Set once the line has been driven since the last clear.
  logic oeSeen = 1'b0;
  initial begin
    linkData = 8'h00;
    linkStp = 1'b0;
  end
  // Records each new cell at the edge that announces it.
  always @(posedge clock) begin
    if (lineStb === 1'b1) begin
      rawQ.push_back(lineLevel);
      decQ.push_back(lineLevel === prevLv);
      prevLv <= lineLevel;
    end
    if (lineOe === 1'b1) begin
      oeSeen <= 1'b1;
    end
  end
  // Forgets what was recorded before a new packet.
  task automatic clear();
    rawQ.delete();
    decQ.delete();
    oeSeen = 1'b0;
  endtask
  // Holds a byte until the edge at which it is taken; called just after an edge.
  task automatic sendByte(input logic [7:0] b, input logic stp, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    linkData <= b;
    linkStp <= stp;
    while (n < 60 && !ok) begin
      @(negedge clock);
      ok = (linkNxt === 1'b1);
      n++;
    end
    @(posedge clock);
    // After the stop byte the link returns the bus to its idle zero.
    if (stp) begin
      linkData <= 8'h00;
      linkStp <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/ulvs_top_tb.sv
// Self-checking testbench of the transmit serializer and supply-valid select.
`timescale 1ns/1ps
`default_nettype none
module ulvs_top_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData, linkData, rxcmdData, lastCmd, rd;
  logic linkStp, linkNxt, lineLevel, lineStb, lineOe, rxcmdStb, ok;
  logic extPin = 1'b0;
  logic intComp = 1'b1;
  logic sessComp = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int stbCnt = 0;
  int run, c0;
  logic expQ[$];
  // The clock runs at 10 MHz.
  always #50 clock = ~clock;
  ulvs_top dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linkData(linkData),
    .linkStp(linkStp), .linkNxt(linkNxt), .lineLevel(lineLevel), .lineStb(lineStb),
    .lineOe(lineOe), .externalValidPin(extPin), .intSupplyComp(intComp),
    .sessionComp(sessComp), .rxcmdStb(rxcmdStb), .rxcmdData(rxcmdData));
  ulvs_link_model link (.clock(clock), .linkNxt(linkNxt), .lineLevel(lineLevel),
    .lineStb(lineStb), .lineOe(lineOe), .linkData(linkData), .linkStp(linkStp));
  // Counts status updates and keeps the byte of the latest one.
  always @(posedge clock) begin
    if (rxcmdStb === 1'b1) begin
      stbCnt++;
      lastCmd <= rxcmdData;
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compares one byte value.
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Compares a recorded cell stream with the expected one.
  task automatic cmpBits(input string nm, input logic g[$]);
    logic bad;
    bad = g.size() != expQ.size();
    // Cell by cell with a case compare, so an unknown cell counts as a mismatch.
    for (int j = 0; j < g.size() && !bad; j++) begin
      if (g[j] !== expQ[j]) bad = 1'b1;
    end
    comparisons++;
    if (bad) begin
      failures++;
      $display("ERROR %s expected %p seen %p", nm, expQ, g);
    end
  endtask
  // One write cycle on the register port.
  task automatic regWrite(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // One read cycle; the data stand only in the following cycle.
  task automatic regRead(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask
  // Reads a register and compares it.
  task automatic chkReg(input logic [5:0] a, input logic [7:0] e);
    regRead(a, rd);
    cmp8("register", e, rd);
  endtask
  // Queues the line bits of a byte, LSB first, with a zero after six ones when stuff is set.
  task automatic addByte(input logic [7:0] b, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      expQ.push_back(b[i]);
      run = b[i] ? run + 1 : 0;
      if (stuff && run == 6) begin
        expQ.push_back(1'b0);
        run = 0;
      end
    end
  endtask
  // Sends one packet in a mode and works out the cells that it must produce.
  task automatic sendPkt(input logic [1:0] m, input logic [7:0] b0, input logic [7:0] b1,
      input int n, input logic [7:0] stop);
    int k;
    expQ.delete();
    run = 0;
    // Every driving mode but raw puts the block's own SYNC byte on the line first.
    if (m == ulvs_pkg::MODE_NORMAL || m == ulvs_pkg::MODE_NOSTUFF) addByte(ulvs_pkg::SYNC_BYTE, 1'b1);
    if (m != ulvs_pkg::MODE_QUIET) addByte(b0, m != ulvs_pkg::MODE_NOSTUFF);
    if (m != ulvs_pkg::MODE_QUIET && n > 1) addByte(b1, m != ulvs_pkg::MODE_NOSTUFF);
    // Normal mode always ends with an EOP; raw mode only when the stop byte is not zero.
    if (m == ulvs_pkg::MODE_NORMAL || (m == ulvs_pkg::MODE_RAW && stop != 8'h00)) begin
      k = (m == ulvs_pkg::MODE_RAW && b1 == ulvs_pkg::SOF_PID) ? 40 : 8;
      expQ.push_back(1'b0);
      repeat (k - 1) expQ.push_back(1'b1);
    end
    regWrite(ulvs_pkg::ADDR_FUNC, ulvs_pkg::RST_FUNC | ({6'h00, m} << ulvs_pkg::MODE_LSB));
    link.clear();
    link.sendByte(ulvs_pkg::CMD_NOPID, 1'b0, ok);
    link.sendByte(b0, 1'b0, ok);
    if (n > 1) link.sendByte(b1, 1'b0, ok);
    link.sendByte(stop, 1'b1, ok);
    if (ok !== 1'b1) cmp8("byte taken", 8'h01, 8'h00);
    k = 0;
    // The packet is over once the line is released.
    while (lineOe !== 1'b0 && k < 400) begin
      @(negedge clock);
      k++;
    end
    repeat (2) @(negedge clock);
    cmp8("line released", 8'h00, {7'h00, lineOe});
  endtask
  // Main sequence.
  initial begin
    logic u, b, i, p, c, e;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    chkReg(ulvs_pkg::ADDR_FUNC, ulvs_pkg::RST_FUNC);
    chkReg(ulvs_pkg::ADDR_INTF, ulvs_pkg::RST_CTRL);
    chkReg(ulvs_pkg::ADDR_OTG, ulvs_pkg::RST_CTRL);
    chkReg(ulvs_pkg::ADDR_RISE, ulvs_pkg::RST_IRQEN);
    chkReg(ulvs_pkg::ADDR_FALL, ulvs_pkg::RST_IRQEN);
    // The comparator is high, so supply valid rises once the synchroniser fills after reset.
    chkReg(ulvs_pkg::ADDR_LATCH, 8'h01 << ulvs_pkg::VBUS_BIT);
    regWrite(6'h3F, 8'hA5);
    chkReg(6'h3F, 8'h00);
    // Every select setting against every pin and comparator level.
    for (int k = 0; k < 32; k++) begin
      {u, b, i, p, c} = 5'(k);
      regWrite(ulvs_pkg::ADDR_OTG, {u, 7'h00});
      regWrite(ulvs_pkg::ADDR_INTF, {1'b0, b, i, 5'h00});
      extPin <= p;
      intComp <= c;
      repeat (4) @(posedge clock);
      e = !u ? c : (b ? (p ^ i) : (c & (i ? !p : p)));
      regRead(ulvs_pkg::ADDR_STAT, rd);
      cmp8("supply valid", {7'h00, e}, {7'h00, rd[ulvs_pkg::VBUS_BIT]});
    end
    regWrite(ulvs_pkg::ADDR_OTG, 8'h00);
    intComp <= 1'b1;
    repeat (4) @(posedge clock);
    regRead(ulvs_pkg::ADDR_LATCH, rd);
    c0 = stbCnt;
    sessComp <= 1'b1;
    repeat (8) @(posedge clock);
    cmp8("rise events", 8'h01, 8'(stbCnt - c0));
    cmp8("status byte", 8'h06, lastCmd & 8'h06);
    chkReg(ulvs_pkg::ADDR_LATCH, 8'h01 << ulvs_pkg::SESS_BIT);
    chkReg(ulvs_pkg::ADDR_LATCH, 8'h00);
    regWrite(ulvs_pkg::ADDR_RISE, 8'h00);
    c0 = stbCnt;
    sessComp <= 1'b0;
    repeat (8) @(posedge clock);
    cmp8("fall events", 8'h01, 8'(stbCnt - c0));
    c0 = stbCnt;
    sessComp <= 1'b1;
    repeat (8) @(posedge clock);
    cmp8("masked events", 8'h00, 8'(stbCnt - c0));
    sendPkt(ulvs_pkg::MODE_RAW, 8'h80, 8'hFF, 2, ulvs_pkg::EOP_BYTE);
    cmpBits("raw stuffed", link.decQ);
    sendPkt(ulvs_pkg::MODE_RAW, 8'h80, ulvs_pkg::SOF_PID, 2, ulvs_pkg::EOP_BYTE);
    cmpBits("raw sof", link.decQ);
    sendPkt(ulvs_pkg::MODE_RAW, 8'h80, 8'h5A, 2, ulvs_pkg::NOEOP_BYTE);
    cmpBits("raw no eop", link.decQ);
    sendPkt(ulvs_pkg::MODE_NORMAL, 8'h2D, 8'h00, 1, ulvs_pkg::NOEOP_BYTE);
    cmpBits("normal", link.decQ);
    sendPkt(ulvs_pkg::MODE_NOSTUFF, 8'hFF, 8'h0F, 2, ulvs_pkg::EOP_BYTE);
    cmpBits("unstuffed", link.rawQ);
    sendPkt(ulvs_pkg::MODE_QUIET, 8'h55, 8'h00, 1, ulvs_pkg::EOP_BYTE);
    cmpBits("quiet cells", link.rawQ);
    cmp8("quiet drive", 8'h00, {7'h00, link.oeSeen});
    conclude();
  end
  // Cuts a hang short well after the tests should have ended.
  initial begin
    #3_000_000;
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
